// [hw/fpec_pkg.sv]
package fpec_pkg;

  // Clock and self-timed operation durations
  localparam int FPEC_CLK_PERIOD_NS = 8;
  localparam int FPEC_ERASE_TIME_NS = 3000000;
  localparam int FPEC_PROGRAM_TIME_NS = 2000000;
  localparam logic [23:0] FPEC_ERASE_CYCLES =
    24'((FPEC_ERASE_TIME_NS + FPEC_CLK_PERIOD_NS - 1) / FPEC_CLK_PERIOD_NS);
  localparam logic [23:0] FPEC_PROGRAM_CYCLES =
    24'((FPEC_PROGRAM_TIME_NS + FPEC_CLK_PERIOD_NS - 1) / FPEC_CLK_PERIOD_NS);

  // Control register field positions and reset value
  localparam int FPEC_BIT_START = 15;
  localparam int FPEC_BIT_ENABLE = 14;
  localparam int FPEC_BIT_ERROR = 13;
  localparam int FPEC_BIT_PGM_ONLY = 12;
  localparam int FPEC_BIT_ERASE = 6;
  localparam int FPEC_OP_LSB = 0;
  localparam logic [15:0] FPEC_CTRL_RST = 16'h0000;

  // Unlock keys and unlock progress
  localparam logic [7:0] FPEC_KEY_FIRST = 8'h55;
  localparam logic [7:0] FPEC_KEY_SECOND = 8'haa;
  localparam logic [1:0] FPEC_KEY_IDLE = 2'h0;
  localparam logic [1:0] FPEC_KEY_GOT_FIRST = 2'h1;
  localparam logic [1:0] FPEC_KEY_ARMED = 2'h2;

  // Operation codes: upper four bits for the xx groups, full six bits for rows
  localparam logic [3:0] FPEC_OPG_ERASE_BOOT = 4'ha;
  localparam logic [3:0] FPEC_OPG_ERASE_ALL = 4'h9;
  localparam logic [3:0] FPEC_OPG_ERASE_CONFIG = 4'h5;
  localparam logic [3:0] FPEC_OPG_ERASE_EEPROM = 4'h4;
  localparam logic [3:0] FPEC_OPG_ERASE_GENERAL = 4'h3;
  localparam logic [3:0] FPEC_OPG_WRITE_ROW = 4'h1;
  localparam logic [5:0] FPEC_OP_ERASE_ROW4 = 6'h1a;
  localparam logic [5:0] FPEC_OP_ERASE_ROW2 = 6'h19;
  localparam logic [5:0] FPEC_OP_ERASE_ROW1 = 6'h18;

  // Address bits below a block boundary
  localparam logic [23:0] FPEC_MASK_ROW1 = 24'h00003f;
  localparam logic [23:0] FPEC_MASK_ROW2 = 24'h00007f;
  localparam logic [23:0] FPEC_MASK_ROW4 = 24'h0000ff;
  localparam logic [23:0] FPEC_MASK_NONE = 24'h000000;
  localparam logic [4:0] FPEC_LAST_LATCH = 5'h1f;

  // Decode answers
  localparam logic [1:0] FPEC_DEC_NOP = 2'h0;
  localparam logic [1:0] FPEC_DEC_LEGAL = 2'h1;
  localparam logic [1:0] FPEC_DEC_REFUSED = 2'h2;

  // Device register selects on the link
  localparam logic [1:0] FPEC_SEL_CTRL = 2'h0;
  localparam logic [1:0] FPEC_SEL_KEY = 2'h1;
  localparam logic [1:0] FPEC_SEL_PAGE = 2'h2;

  // Core-end software addresses
  localparam logic [2:0] FPEC_HADDR_CTRL = 3'h0;
  localparam logic [2:0] FPEC_HADDR_KEY = 3'h1;
  localparam logic [2:0] FPEC_HADDR_PAGE = 3'h2;
  localparam logic [2:0] FPEC_HADDR_TBL_HI = 3'h3;
  localparam logic [2:0] FPEC_HADDR_TBL_OFS = 3'h4;
  localparam logic [2:0] FPEC_HADDR_TBL_LO = 3'h5;
  localparam logic [2:0] FPEC_HADDR_STATUS = 3'h6;
  localparam logic [1:0] FPEC_NOP_SLOTS = 2'h2;
  localparam logic [15:0] FPEC_TBL_STEP = 16'h0002;

  typedef enum logic [2:0] {
    FPEC_ST_IDLE = 3'b001,
    FPEC_ST_STREAM = 3'b010,
    FPEC_ST_WAIT = 3'b100
  } fpec_state_e;

endpackage : fpec_pkg

// [hw/fpec_if.sv]
`timescale 1ns/1ps
interface fpec_if;
  logic reg_we;
  logic reg_re;
  logic [1:0] reg_sel;
  logic [15:0] reg_wdata;
  logic [15:0] reg_rdata;
  logic tbl_we;
  logic [15:0] tbl_offset;
  logic [23:0] tbl_data;
  logic stall;

  modport dev (
    input reg_we, reg_re, reg_sel, reg_wdata, tbl_we, tbl_offset, tbl_data,
    output reg_rdata, stall
  );
  modport core (
    output reg_we, reg_re, reg_sel, reg_wdata, tbl_we, tbl_offset, tbl_data,
    input reg_rdata, stall
  );
endinterface : fpec_if

// [hw/fpec_device.sv]
`timescale 1ns/1ps
// How it works
// - Start bit launches self-timed op, clears after
// - Enable bit permits, zero inhibits operations
// - Error flag on bad sequence, cleared on success
// - Erase bit picks erase or program
// - Boot and full erase only in serial mode
// - Codes erase four, two, one rows
// - Config, EEPROM, general block erase codes
// - Program code writes row from latches
// - Unassigned codes do nothing
// - Rows chosen from table pointer address
// - Program-only bit matters for EEPROM only
// - Bits eleven to seven read zero
// - Keys 55h then AAh before start
// - Core stalled for whole operation
// - Software puts two no-ops, then waits
// - Software reads, modifies, erases, reloads, programs row
// - Software sets up row erase before unlocking
// - Start set by software, cleared by hardware
// - Table writes held in latches until programming
module fpec_device #(
  parameter logic [23:0] erase_cycles = fpec_pkg::FPEC_ERASE_CYCLES,
  parameter logic [23:0] program_cycles = fpec_pkg::FPEC_PROGRAM_CYCLES
) (
  input wire logic clk,
  input wire logic sys_rst,
  fpec_if.dev link,
  input wire logic serial_prog_mode,
  output logic arr_erase,
  output logic [5:0] arr_op_code,
  output logic [23:0] arr_addr,
  output logic arr_prog_only,
  output logic arr_wr_en,
  output logic [23:0] arr_wr_addr,
  output logic [23:0] arr_wr_data
);
  import fpec_pkg::*;

  typedef struct packed {
    fpec_state_e st;
    logic start;
    logic enable;
    logic error;
    logic pgm_only;
    logic erase;
    logic [5:0] op;
    logic [1:0] key;
    logic [7:0] page;
    logic [15:0] ptr;
    logic [23:0] cnt;
    logic [4:0] idx;
    logic [15:0] rdata;
    logic [2:0] msync;
    logic mode;
    logic erase_p;
    logic [5:0] op_out;
    logic [23:0] base;
    logic prog_only;
    logic wr_en;
    logic [23:0] wr_addr;
    logic [23:0] wr_data;
    logic [31:0][23:0] latch;
  } fpec_dev_s;

  fpec_dev_s q;
  fpec_dev_s d;
  logic [15:0] ctrl_view;
  logic [1:0] dec;
  logic [23:0] dec_mask;
  logic [5:0] w_op;
  logic w_erase;

  // Classify an operation code against erase select and serial mode
  function automatic logic [1:0] fpec_classify(input logic [5:0] op, input logic er,
                                               input logic serial);
    logic [1:0] r;
    r = FPEC_DEC_NOP;
    if (er) begin
      if (op[5:2] == FPEC_OPG_ERASE_BOOT || op[5:2] == FPEC_OPG_ERASE_ALL) begin
        r = serial ? FPEC_DEC_LEGAL : FPEC_DEC_REFUSED;
      end else if (op == FPEC_OP_ERASE_ROW4 || op == FPEC_OP_ERASE_ROW2 ||
                   op == FPEC_OP_ERASE_ROW1) begin
        r = FPEC_DEC_LEGAL;
      end else if (op[5:2] == FPEC_OPG_ERASE_CONFIG || op[5:2] == FPEC_OPG_ERASE_EEPROM ||
                   op[5:2] == FPEC_OPG_ERASE_GENERAL) begin
        r = FPEC_DEC_LEGAL;
      end
    end else if (op[5:2] == FPEC_OPG_WRITE_ROW) begin
      r = FPEC_DEC_LEGAL;
    end
    return r;
  endfunction : fpec_classify

  // Block boundary of the rows that an operation touches
  function automatic logic [23:0] fpec_row_mask(input logic [5:0] op, input logic er);
    logic [23:0] m;
    m = FPEC_MASK_NONE;
    if (!er) begin
      m = FPEC_MASK_ROW1;
    end else if (op == FPEC_OP_ERASE_ROW4) begin
      m = FPEC_MASK_ROW4;
    end else if (op == FPEC_OP_ERASE_ROW2) begin
      m = FPEC_MASK_ROW2;
    end else if (op == FPEC_OP_ERASE_ROW1) begin
      m = FPEC_MASK_ROW1;
    end
    return m;
  endfunction : fpec_row_mask

  // Readable image of the control register
  always_comb begin
    ctrl_view = 16'h0000;
    ctrl_view[FPEC_BIT_START] = q.start;
    ctrl_view[FPEC_BIT_ENABLE] = q.enable;
    ctrl_view[FPEC_BIT_ERROR] = q.error;
    ctrl_view[FPEC_BIT_PGM_ONLY] = q.pgm_only;
    ctrl_view[FPEC_BIT_ERASE] = q.erase;
    ctrl_view[FPEC_OP_LSB +: 6] = q.op;
  end

  // Decode of the control word being written
  assign w_op = link.reg_wdata[FPEC_OP_LSB +: 6];
  assign w_erase = link.reg_wdata[FPEC_BIT_ERASE];
  assign dec = fpec_classify(w_op, w_erase, q.mode);
  assign dec_mask = fpec_row_mask(w_op, w_erase);

  // Next-state logic
  always_comb begin
    d = q;
    d.erase_p = 1'b0;
    d.wr_en = 1'b0;
    d.rdata = 16'h0000;
    d.msync = {q.msync[1:0], serial_prog_mode};
    if (q.msync[2] == q.msync[1]) begin
      d.mode = q.msync[2];
    end
    if (link.reg_re) begin
      case (link.reg_sel)
        FPEC_SEL_CTRL: d.rdata = ctrl_view;
        FPEC_SEL_PAGE: d.rdata = {8'h00, q.page};
        default: d.rdata = 16'h0000;
      endcase
    end
    case (q.st)
      FPEC_ST_IDLE: begin
        if (link.tbl_we) begin
          d.key = FPEC_KEY_IDLE;
          d.latch[link.tbl_offset[5:1]] = link.tbl_data;
          d.ptr = link.tbl_offset;
        end else if (link.reg_we) begin
          d.key = FPEC_KEY_IDLE;
          case (link.reg_sel)
            FPEC_SEL_KEY: begin
              if (link.reg_wdata[7:0] == FPEC_KEY_FIRST) begin
                d.key = FPEC_KEY_GOT_FIRST;
              end else if (link.reg_wdata[7:0] == FPEC_KEY_SECOND &&
                           q.key == FPEC_KEY_GOT_FIRST) begin
                d.key = FPEC_KEY_ARMED;
              end
            end
            FPEC_SEL_PAGE: d.page = link.reg_wdata[7:0];
            FPEC_SEL_CTRL: begin
              d.enable = link.reg_wdata[FPEC_BIT_ENABLE];
              d.error = link.reg_wdata[FPEC_BIT_ERROR];
              d.pgm_only = link.reg_wdata[FPEC_BIT_PGM_ONLY];
              d.erase = w_erase;
              d.op = w_op;
              if (link.reg_wdata[FPEC_BIT_START]) begin
                if (q.key != FPEC_KEY_ARMED || !link.reg_wdata[FPEC_BIT_ENABLE] ||
                    dec == FPEC_DEC_REFUSED) begin
                  d.error = 1'b1;
                end else if (dec == FPEC_DEC_LEGAL) begin
                  d.start = 1'b1;
                  d.base = {q.page, q.ptr} & ~dec_mask;
                  d.op_out = w_op;
                  d.prog_only = link.reg_wdata[FPEC_BIT_PGM_ONLY] & w_erase &
                                (w_op[5:2] == FPEC_OPG_ERASE_EEPROM);
                  d.idx = 5'h00;
                  if (w_erase) begin
                    d.erase_p = 1'b1;
                    d.cnt = erase_cycles - 24'h000001;
                    d.st = FPEC_ST_WAIT;
                  end else begin
                    d.st = FPEC_ST_STREAM;
                  end
                end
              end
            end
            default: d.key = FPEC_KEY_IDLE;
          endcase
        end
      end
      FPEC_ST_STREAM: begin
        d.wr_en = 1'b1;
        d.wr_addr = q.base + {18'h00000, q.idx, 1'b0};
        d.wr_data = q.latch[q.idx];
        d.idx = q.idx + 5'h01;
        if (q.idx == FPEC_LAST_LATCH) begin
          d.cnt = program_cycles - 24'h000001;
          d.st = FPEC_ST_WAIT;
        end
      end
      FPEC_ST_WAIT: begin
        d.cnt = q.cnt - 24'h000001;
        if (q.cnt == 24'h000000) begin
          d.start = 1'b0;
          d.error = 1'b0;
          d.st = FPEC_ST_IDLE;
        end
      end
      default: d.st = FPEC_ST_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      q <= '0;
      q.st <= FPEC_ST_IDLE;
      {q.start, q.enable, q.error, q.pgm_only} <= FPEC_CTRL_RST[15:12];
    end else begin
      q <= d;
    end
  end

  // Outputs
  assign link.stall = (q.st != FPEC_ST_IDLE);
  assign link.reg_rdata = q.rdata;
  assign arr_erase = q.erase_p;
  assign arr_op_code = q.op_out;
  assign arr_addr = q.base;
  assign arr_prog_only = q.prog_only;
  assign arr_wr_en = q.wr_en;
  assign arr_wr_addr = q.wr_addr;
  assign arr_wr_data = q.wr_data;

endmodule : fpec_device

// [hw/fpec_core_end.sv]
`timescale 1ns/1ps
module fpec_core_end (
  input wire logic clk,
  input wire logic sys_rst,
  fpec_if.core link,
  input wire logic [2:0] sw_addr,
  input wire logic [15:0] sw_wdata,
  input wire logic sw_we,
  input wire logic sw_re,
  output logic [15:0] sw_rdata,
  output logic core_stalled
);
  import fpec_pkg::*;

  typedef struct packed {
    logic [1:0] nop_cnt;
    logic dropped;
    logic [7:0] tbl_hi;
    logic [15:0] tbl_ofs;
    logic rd_dev;
    logic [15:0] rdata;
  } fpec_core_s;

  fpec_core_s q;
  fpec_core_s d;
  logic blocked;
  logic dev_acc;

  // Device accesses refused during stall and the two no-op slots
  assign blocked = link.stall | (q.nop_cnt != 2'h0);
  assign dev_acc = (sw_addr == FPEC_HADDR_CTRL) | (sw_addr == FPEC_HADDR_KEY) |
                   (sw_addr == FPEC_HADDR_PAGE) | (sw_addr == FPEC_HADDR_TBL_LO);

  // Requests forwarded to the device
  always_comb begin
    link.reg_we = sw_we & ~blocked & (sw_addr != FPEC_HADDR_TBL_LO) & dev_acc;
    link.reg_re = sw_re & ~blocked & (sw_addr != FPEC_HADDR_TBL_LO) & dev_acc;
    link.reg_sel = sw_addr[1:0];
    link.reg_wdata = sw_wdata;
    link.tbl_we = sw_we & ~blocked & (sw_addr == FPEC_HADDR_TBL_LO);
    link.tbl_offset = q.tbl_ofs;
    link.tbl_data = {q.tbl_hi, sw_wdata};
  end

  // Next-state logic
  always_comb begin
    d = q;
    d.rd_dev = 1'b0;
    d.rdata = 16'h0000;
    if (q.nop_cnt != 2'h0) begin
      d.nop_cnt = q.nop_cnt - 2'h1;
    end
    if (sw_we) begin
      case (sw_addr)
        FPEC_HADDR_TBL_HI: d.tbl_hi = sw_wdata[7:0];
        FPEC_HADDR_TBL_OFS: d.tbl_ofs = sw_wdata;
        FPEC_HADDR_TBL_LO: begin
          if (!blocked) begin
            d.tbl_ofs = q.tbl_ofs + FPEC_TBL_STEP;
          end
        end
        FPEC_HADDR_STATUS: begin
          if (sw_wdata[1]) begin
            d.dropped = 1'b0;
          end
        end
        FPEC_HADDR_CTRL: begin
          if (!blocked && sw_wdata[FPEC_BIT_START]) begin
            d.nop_cnt = FPEC_NOP_SLOTS;
          end
        end
        default: d.tbl_hi = q.tbl_hi;
      endcase
    end
    if (sw_re) begin
      case (sw_addr)
        FPEC_HADDR_STATUS: d.rdata = {14'h0000, q.dropped, blocked};
        FPEC_HADDR_TBL_HI: d.rdata = {8'h00, q.tbl_hi};
        FPEC_HADDR_TBL_OFS: d.rdata = q.tbl_ofs;
        default: d.rd_dev = link.reg_re;
      endcase
    end
    // Refused access sets the sticky flag; set beats clear
    if ((sw_we | sw_re) & dev_acc & blocked) begin
      d.dropped = 1'b1;
    end
  end

  // State register
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign sw_rdata = q.rd_dev ? link.reg_rdata : q.rdata;
  assign core_stalled = link.stall;

endmodule : fpec_core_end

// [bench/fpec_props.sv]
`timescale 1ns/1ps
module fpec_props #(
  parameter int min_busy = 20,
  parameter int max_busy = 48
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic reg_we,
  input wire logic reg_re,
  input wire logic [1:0] reg_sel,
  input wire logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata,
  input wire logic tbl_we,
  input wire logic stall
);
  import fpec_pkg::*;
  logic [1:0] key_q;
  logic [1:0] key_d;
  logic [7:0] run_q;
  logic ok_q;
  logic wctl;
  logic wkey;
  assign wctl = reg_we && reg_sel == FPEC_SEL_CTRL;
  assign wkey = reg_we && reg_sel == FPEC_SEL_KEY;
  // Unlock progress as seen on the link
  always_comb begin
    key_d = (reg_we || tbl_we) ? FPEC_KEY_IDLE : key_q;
    if (wkey && reg_wdata[7:0] == FPEC_KEY_FIRST) key_d = FPEC_KEY_GOT_FIRST;
    if (wkey && reg_wdata[7:0] == FPEC_KEY_SECOND && key_q == FPEC_KEY_GOT_FIRST) begin
      key_d = FPEC_KEY_ARMED;
    end
  end
  // Busy run length and clean finish flag
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      key_q <= FPEC_KEY_IDLE;
      run_q <= 8'h00;
      ok_q <= 1'b0;
    end else begin
      key_q <= key_d;
      run_q <= stall ? run_q + 8'h01 : 8'h00;
      ok_q <= $fell(stall) ? 1'b1 : (wctl ? 1'b0 : ok_q);
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  a_gap_bits_zero: assert property (
    reg_re && reg_sel == FPEC_SEL_CTRL |=> reg_rdata[11:7] == 5'h00)
    else $error("gap bits of control read nonzero");
  a_key_write_only: assert property (
    reg_re && reg_sel == FPEC_SEL_KEY |=> reg_rdata == 16'h0000)
    else $error("key register read nonzero");
  a_unlock_starts: assert property (
    key_q == FPEC_KEY_ARMED && wctl && !stall && reg_wdata[15:14] == 2'b11 && reg_wdata[6]
    && reg_wdata[5:0] == FPEC_OP_ERASE_ROW1 |=> stall)
    else $error("unlocked row erase did not start");
  a_locked_no_op: assert property (
    key_q != FPEC_KEY_ARMED && wctl && !stall |=> !stall)
    else $error("operation started without unlock");
  a_enable_gates: assert property (
    wctl && !reg_wdata[14] && !stall |=> !stall)
    else $error("operation started with enable low");
  a_busy_held: assert property ($fell(stall) |-> run_q >= 8'(min_busy))
    else $error("stall ended too early");
  a_busy_bounded: assert property (stall |-> run_q < 8'(max_busy))
    else $error("stall did not end in time");
  a_no_access_busy: assert property (stall |-> !reg_we && !tbl_we)
    else $error("access reached device while stalled");
  a_clean_finish: assert property (
    ok_q && reg_re && reg_sel == FPEC_SEL_CTRL |=> !reg_rdata[15] && !reg_rdata[13])
    else $error("start or error bit set after normal finish");
  c_unlock: cover property (key_q == FPEC_KEY_ARMED && wctl && reg_wdata[15]);
  c_refused: cover property (key_q != FPEC_KEY_ARMED && wctl && reg_wdata[15]);
  c_finish: cover property ($fell(stall));
endmodule : fpec_props

// [bench/tb.sv]
`timescale 1ns/1ps
module tb;
  import fpec_pkg::*;
  localparam logic [23:0] ELEN = 24'h000014;
  localparam logic [23:0] PLEN = 24'h00000a;
  logic clk;
  logic sys_rst;
  logic serial_prog_mode;
  logic [2:0] sw_addr;
  logic [15:0] sw_wdata;
  logic sw_we;
  logic sw_re;
  logic [15:0] sw_rdata;
  logic core_stalled;
  logic arr_erase;
  logic [5:0] arr_op_code;
  logic [23:0] arr_addr;
  logic arr_prog_only;
  logic arr_wr_en;
  logic [23:0] arr_wr_addr;
  logic [23:0] arr_wr_data;
  logic [23:0] words [32];
  logic [23:0] seen [32];
  logic [23:0] wr_last;
  logic [5:0] ops [12] = '{6'h28, 6'h24, 6'h1a, 6'h19, 6'h18, 6'h14, 6'h10, 6'h0c, 6'h04,
                           6'h3f, 6'h20, 6'h1b};
  int n_mismatch = 0;
  int checks = 0;
  int cycles = 0;
  int n_erase = 0;
  int n_wr = 0;
  int run = 0;
  int last_run = 0;
  fpec_if link ();
  fpec_device #(.erase_cycles(ELEN), .program_cycles(PLEN)) u_fpec_device (
    .clk(clk), .sys_rst(sys_rst), .link(link), .serial_prog_mode(serial_prog_mode),
    .arr_erase(arr_erase), .arr_op_code(arr_op_code), .arr_addr(arr_addr),
    .arr_prog_only(arr_prog_only), .arr_wr_en(arr_wr_en), .arr_wr_addr(arr_wr_addr),
    .arr_wr_data(arr_wr_data));
  fpec_core_end u_fpec_core_end (
    .clk(clk), .sys_rst(sys_rst), .link(link), .sw_addr(sw_addr), .sw_wdata(sw_wdata),
    .sw_we(sw_we), .sw_re(sw_re), .sw_rdata(sw_rdata), .core_stalled(core_stalled));
  fpec_props #(.min_busy(20), .max_busy(48)) props_mon (
    .clk(clk), .sys_rst(sys_rst), .reg_we(link.reg_we), .reg_re(link.reg_re),
    .reg_sel(link.reg_sel), .reg_wdata(link.reg_wdata), .reg_rdata(link.reg_rdata),
    .tbl_we(link.tbl_we), .stall(link.stall));
  // Free running clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // Array activity, busy length and hang guard
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (arr_erase === 1'b1) n_erase <= n_erase + 1;
    if (arr_wr_en === 1'b1) begin
      n_wr <= n_wr + 1;
      seen[arr_wr_addr[5:1]] <= arr_wr_data;
      wr_last <= arr_wr_addr;
    end
    run <= (link.stall === 1'b1) ? run + 1 : 0;
    if (link.stall !== 1'b1 && run != 0) last_run <= run;
    if (cycles == 40000) begin
      n_mismatch++;
      final_report();
    end
  end
  task automatic cmp(input string name, input logic [23:0] exp, input logic [23:0] got);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask : cmp
  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge clk);
    sw_we <= 1'b1;
    sw_addr <= a;
    sw_wdata <= d;
    @(posedge clk);
    sw_we <= 1'b0;
  endtask : wr
  task automatic rd(input logic [2:0] a, output logic [15:0] d);
    @(posedge clk);
    sw_re <= 1'b1;
    sw_addr <= a;
    @(posedge clk);
    sw_re <= 1'b0;
    #1 d = sw_rdata;
  endtask : rd
  // Whether a control word names an assigned operation
  function automatic logic fit(input logic [15:0] cw);
    if (!cw[6]) return cw[5:2] == 4'h1;
    return cw[5:2] inside {4'ha, 4'h9, 4'h5, 4'h4, 4'h3} || cw[5:0] inside {6'h18, 6'h19, 6'h1a};
  endfunction : fit
  // Address bits cleared below the block base
  function automatic logic [23:0] smask(input logic [15:0] cw);
    if (!cw[6] || cw[5:0] == 6'h18) return 24'h00003f;
    if (cw[5:0] == 6'h19) return 24'h00007f;
    return (cw[5:0] == 6'h1a) ? 24'h0000ff : 24'h000000;
  endfunction : smask
  // Load a row of latches, try a start, check the outcome
  task automatic launch(input logic [15:0] cw, input int keys, input logic ser);
    logic [7:0] pg;
    logic [15:0] ofs;
    logic [15:0] d;
    logic ok;
    logic err;
    int e0;
    int w0;
    @(posedge clk);
    serial_prog_mode <= ser;
    pg = 8'($urandom);
    ofs = 16'($urandom) & 16'hffc0;
    e0 = n_erase;
    w0 = n_wr;
    wr(FPEC_HADDR_PAGE, {8'h00, pg});
    wr(FPEC_HADDR_TBL_OFS, ofs);
    for (int i = 0; i < 32; i++) begin
      words[i] = 24'($urandom);
      wr(FPEC_HADDR_TBL_HI, {8'h00, words[i][23:16]});
      wr(FPEC_HADDR_TBL_LO, words[i][15:0]);
    end
    // Staged table offset and high byte read back
    rd(FPEC_HADDR_TBL_OFS, d);
    cmp("table offset", {8'h00, ofs + 16'h0040}, {8'h00, d});
    rd(FPEC_HADDR_TBL_HI, d);
    cmp("table high", {16'h0000, words[31][23:16]}, {8'h00, d});
    ok = keys > 1 && cw[14] && fit(cw) && !(cw[6] && cw[5:4] == 2'b10 && !ser);
    err = ok ? 1'b0 : ((keys > 1 && cw[14] && !fit(cw)) ? cw[13] : 1'b1);
    wr(FPEC_HADDR_CTRL, cw & 16'h7fff);
    if (keys > 0) wr(FPEC_HADDR_KEY, 16'h0055);
    if (keys == 1) wr(FPEC_HADDR_PAGE, {8'h00, pg});
    if (keys > 0) wr(FPEC_HADDR_KEY, 16'h00aa);
    cmp("early row writes", 24'h0, 24'(n_wr - w0));
    wr(FPEC_HADDR_CTRL, cw | 16'h8000);
    repeat (2) @(posedge clk);
    #1 cmp("stalled", 24'(ok), 24'(core_stalled));
    if (ok) begin
      wr(FPEC_HADDR_CTRL, 16'h0000);
      rd(FPEC_HADDR_STATUS, d);
      cmp("dropped while busy", 24'h1, 24'(d[1]));
      cmp("blocked while busy", 24'h1, 24'(d[0]));
      wr(FPEC_HADDR_STATUS, 16'h0002);
    end
    for (int t = 0; t < 100 && core_stalled !== 1'b0; t++) @(posedge clk);
    repeat (3) @(posedge clk);
    rd(FPEC_HADDR_CTRL, d);
    cmp("control", {9'h000, cw[14], err, cw[12], 5'h00, cw[6:0]}, {8'h00, d});
    cmp("erase pulses", 24'(ok && cw[6]), 24'(n_erase - e0));
    cmp("row writes", (ok && !cw[6]) ? 24'h20 : 24'h0, 24'(n_wr - w0));
    if (ok) begin
      cmp("op code", {18'h0, cw[5:0]}, {18'h0, arr_op_code});
      cmp("base", {pg, ofs + 16'h003e} & ~smask(cw), arr_addr);
      cmp("program only", 24'(cw[6] && cw[5:2] == 4'h4 && cw[12]), 24'(arr_prog_only));
      cmp("busy", cw[6] ? ELEN : PLEN + 24'h20, 24'(last_run));
      for (int i = 0; i < 32 && !cw[6]; i++) cmp("latch word", words[i], seen[i]);
      if (!cw[6]) cmp("last row address", ({pg, ofs} & 24'hffffc0) + 24'h00003e, wr_last);
    end
  endtask : launch
  task automatic final_report;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : final_report
  initial begin
    logic [15:0] d;
    logic [5:0] op;
    logic [15:0] cw;
    sys_rst = 1'b1;
    serial_prog_mode = 1'b0;
    sw_addr = 3'h0;
    sw_wdata = 16'h0000;
    sw_we = 1'b0;
    sw_re = 1'b0;
    void'($urandom(32'he6de013d));
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    // Reset values of control, key and an unmapped place
    for (int a = 0; a < 3; a++) begin
      rd((a == 2) ? 3'h7 : 3'(a), d);
      cmp("reset read", 24'h0, {8'h00, d});
    end
    // Every operation code once, unlocked, serial mode on
    for (int i = 0; i < 12; i++) begin
      op = ops[i] | ((ops[i][5:2] == 4'h6) ? 6'h00 : 6'($urandom % 4));
      launch({3'b010, 1'($urandom), 5'h00, ops[i] != 6'h04, op}, 2, 1'b1);
    end
    // Random unlock, enable, erase select, gap bits and serial mode
    for (int i = 0; i < 40; i++) begin
      op = ops[$urandom % 12] | 6'($urandom % 4);
      cw = (16'($urandom) & 16'h3fc0) | {1'b0, 1'($urandom % 4 != 0), 8'h00, op};
      launch(cw, $urandom % 4, 1'($urandom));
    end
    // Reset in the middle of an erase
    wr(FPEC_HADDR_CTRL, 16'h4058);
    wr(FPEC_HADDR_KEY, 16'h0055);
    wr(FPEC_HADDR_KEY, 16'h00aa);
    wr(FPEC_HADDR_CTRL, 16'hc058);
    repeat (5) @(posedge clk);
    sys_rst <= 1'b1;
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    rd(FPEC_HADDR_CTRL, d);
    cmp("control after reset", 24'h0, {8'h00, d});
    cmp("stall after reset", 24'h0, 24'(core_stalled));
    final_report();
  end
endmodule : tb
